/* File: inc/clt_defines.svh */
// Constants of the composite limit tester: widths, codes, limits.
// Assumes nothing; included by the package and the design files.
`ifndef CLT_DEFINES_SVH
`define CLT_DEFINES_SVH

`define CLT_DW        72
`define CLT_PW        14
`define CLT_NTEST     12
`define CLT_NPIN      14
`define CLT_PIN_NONE  4'h0
`define CLT_PIN_LAST  4'hE
`define CLT_IDX_FIRST 4'h1
`define CLT_IDX_LAST  4'hC
`define CLT_PAT_CLEAR 14'h0000
`define CLT_BIN_NONE  4'h0
`define CLT_OFS_MAX   72'h3635C952D2CE25C000
`define CLT_RES_DIV0  72'h7FFFFFFFFFFFFFFFFF
`define CLT_ZERO      72'h000000000000000000

`endif

/* File: inc/clt_pkg.sv */
// Types shared by the composite limit tester modules.
// Assumes clt_defines.svh is on the include path.
`include "clt_defines.svh"

package clt_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_JUDGE = 2'b10
    } clt_state_type;

    typedef enum logic [1:0] {
        FEED_MATH  = 2'b00,
        FEED_VOLTS = 2'b01,
        FEED_AMPS  = 2'b10,
        FEED_RES   = 2'b11
    } clt_feed_sel_type;

    typedef enum logic {
        FUNC_COMP  = 1'b0,
        FUNC_LIMIT = 1'b1
    } clt_func_type;

    typedef struct packed {
        logic                      enable;
        clt_func_type              func;
        clt_feed_sel_type          feed;
        logic                      fail_on_in;
        logic [`CLT_PW-1:0]        fail_pat;
        logic [`CLT_PW-1:0]        pass_pat;
        logic [`CLT_PW-1:0]        up_pat;
        logic [`CLT_PW-1:0]        low_pat;
        logic signed [`CLT_DW-1:0] up_limit;
        logic signed [`CLT_DW-1:0] low_limit;
    } clt_test_cfg_type;

    typedef struct packed {
        logic signed [`CLT_DW-1:0] math;
        logic signed [`CLT_DW-1:0] volts;
        logic signed [`CLT_DW-1:0] amps;
        logic signed [`CLT_DW-1:0] res;
    } clt_feeds_type;

    typedef struct packed {
        logic pass;
        logic comp_fail;
        logic up_fail;
        logic low_fail;
    } clt_verdict_type;

endpackage

/* File: logic/clt_judge.sv */
// One individual test: picks its feed and judges it.
// Assumes feeds already carry the offset correction.
`include "clt_defines.svh"

module clt_judge (
    input  clt_pkg::clt_test_cfg_type cfg,
    input  clt_pkg::clt_feeds_type    feeds,
    input  wire logic                 in_comp,
    output clt_pkg::clt_verdict_type  verdict
);
    import clt_pkg::*;

    logic signed [`CLT_DW-1:0] value;

    // ------------------------------------------------------------
    // Feed selection and verdict
    // ------------------------------------------------------------
    always_comb begin
        case (cfg.feed)
            FEED_MATH:  value = feeds.math;
            FEED_VOLTS: value = feeds.volts;
            FEED_AMPS:  value = feeds.amps;
            FEED_RES:   value = feeds.res;
            default:    value = feeds.math;
        endcase
        verdict = '0;
        if (cfg.func == FUNC_COMP) begin // RQ13
            // IN fails on entering, OUT on leaving compliance
            verdict.comp_fail = cfg.fail_on_in ? in_comp : ~in_comp; // RQ14
        end else begin
            // Bounds are inclusive
            verdict.up_fail  = value > $signed(cfg.up_limit); // RQ19
            verdict.low_fail = value < $signed(cfg.low_limit); // RQ19
        end
        verdict.pass = ~(verdict.comp_fail | verdict.up_fail
                         | verdict.low_fail);
    end

endmodule // clt_judge

/* File: logic/clt_top.sv */
// Composite pass/fail judgement with handler pin output.
// Assumes all inputs synchronous to SYS_CLK; handler busy, done and begin pins active low.
//
// Function
// RQ1: Master enable; disabled means no judgement, no drive.
// RQ2: Grading or sorting mode by configuration.
// RQ3: Auto clear wipes results and pattern lines.
// RQ4: Grading updates after each test or at end.
// RQ5: Offset cancel subtracts clamped offset before judging.
// RQ6: Composite pass pattern grading, fail pattern sorting.
// RQ7: Pin assignment 1 to 14, zero unused.
// RQ8: Pattern on consecutive pins, LSB lowest.
// RQ9: Busy, done outputs and begin input on pins.
// RQ10: Only digital-function pins carry handler signals.
// RQ11: Feed is math, volts, amps or resistance.
// RQ12: Twelve indexed tests with own enable, bins.
// RQ13: Each test is compliance or limit check.
// RQ14: Compliance fails on entering or on leaving.
// RQ15: Compliance check shows its own fail pattern.
// RQ16: Above upper limit shows upper pattern.
// RQ17: Below lower limit shows lower pattern.
// RQ18: Chosen pattern driven onto pattern pin group.
// RQ19: Inclusive limits pass; violated bound fails.
// RQ20: Busy until judged, then one done pulse.
`include "clt_defines.svh"

module clt_top (
    input  wire logic                     SYS_CLK,
    input  wire logic                     RESET_N,
    input  wire logic                     TEST_ENABLE,
    input  wire logic                     MODE_SORT,
    input  wire logic                     AUTO_CLEAR,
    input  wire logic                     UPDATE_IMMEDIATE,
    input  wire logic                     OFFSET_CANCEL,
    input  wire logic signed [`CLT_DW-1:0] OFFSET,
    input  wire logic [`CLT_PW-1:0]       COMP_PASS_PATTERN,
    input  wire logic [`CLT_PW-1:0]       COMP_FAIL_PATTERN,
    input  wire logic [3:0]               PATTERN_PIN_LOW,
    input  wire logic [3:0]               PATTERN_PIN_HIGH,
    input  wire logic [3:0]               BUSY_PIN,
    input  wire logic [3:0]               BEGIN_PIN,
    input  wire logic [3:0]               DONE_PIN,
    input  wire logic [`CLT_NPIN:1]       PIN_IS_DIGITAL,
    input  clt_pkg::clt_test_cfg_type     TEST_CFG [`CLT_NTEST],
    input  wire logic                     MEAS_VALID,
    input  wire logic signed [`CLT_DW-1:0] MATH_RESULT,
    input  wire logic signed [`CLT_DW-1:0] VOLTS,
    input  wire logic signed [`CLT_DW-1:0] AMPS,
    input  wire logic                     IN_COMPLIANCE,
    input  wire logic [`CLT_NPIN:1]       HANDLER_IO_PIN_IN,
    output logic [`CLT_NPIN:1]            HANDLER_IO_PIN_OUT,
    output logic [`CLT_NPIN:1]            HANDLER_IO_PIN_OE,
    output logic                          TEST_BUSY,
    output logic                          TEST_DONE,
    output logic [3:0]                    RESULT_BIN,
    output logic                          RESULT_PASS,
    output logic [`CLT_PW-1:0]            RESULT_PATTERN
);
    import clt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    clt_state_type             state;
    clt_state_type             next_state;
    logic [3:0]                idx;
    logic [3:0]                next_idx;
    logic [`CLT_PW-1:0]        pattern;
    logic [`CLT_PW-1:0]        next_pattern;
    logic [3:0]                bin;
    logic [3:0]                next_bin;
    logic                      pass;
    logic                      next_pass;
    logic                      busy;
    logic                      next_busy;
    logic                      done;
    logic                      next_done;
    logic                      begin_prev;
    logic                      next_begin_prev;
    clt_feeds_type             feeds;
    clt_feeds_type             next_feeds;
    logic [`CLT_NPIN:1]        pin_out;
    logic [`CLT_NPIN:1]        next_pin_out;
    logic [`CLT_NPIN:1]        pin_oe;
    logic [`CLT_NPIN:1]        next_pin_oe;

    logic                      begin_level;
    logic                      start;
    logic signed [`CLT_DW-1:0] ofs;
    logic signed [`CLT_DW-1:0] ofs_min;
    logic [3:0]                idx_m1;
    clt_test_cfg_type          cur_cfg;
    clt_verdict_type           cur_v;
    clt_verdict_type           verdict [`CLT_NTEST];

    // Pin number usable only if assigned and set to digital I/O
    function automatic logic pin_ok(input logic [3:0] num,
                                    input logic [`CLT_NPIN:1] dig);
        logic ok;
        ok = 1'b0;
        if (num != `CLT_PIN_NONE && num <= `CLT_PIN_LAST) begin // RQ7
            ok = dig[num]; // RQ10
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Individual tests, all judged in parallel
    // ------------------------------------------------------------
    for (genvar t = 0; t < `CLT_NTEST; t++) begin : g_test
        clt_judge u_judge (
            .cfg     (TEST_CFG[t]),
            .feeds   (feeds),
            .in_comp (IN_COMPLIANCE),
            .verdict (verdict[t])
        );
    end

    // Begin pin: falling edge starts a test; idle level high
    assign begin_level = pin_ok(BEGIN_PIN, PIN_IS_DIGITAL)
                         ? HANDLER_IO_PIN_IN[BEGIN_PIN] : 1'b1; // RQ9
    assign start = begin_prev & ~begin_level;

    // Offset clamped to its legal range so wrap cannot flip a verdict
    assign ofs_min = `CLT_ZERO - $signed(`CLT_OFS_MAX);
    always_comb begin
        if (!OFFSET_CANCEL) begin
            ofs = `CLT_ZERO;
        end else if (OFFSET > $signed(`CLT_OFS_MAX)) begin
            ofs = `CLT_OFS_MAX; // RQ5
        end else if (OFFSET < ofs_min) begin
            ofs = ofs_min; // RQ5
        end else begin
            ofs = OFFSET;
        end
    end

    assign idx_m1  = idx - `CLT_IDX_FIRST;
    assign cur_cfg = TEST_CFG[idx_m1];
    assign cur_v   = verdict[idx_m1];

    // ------------------------------------------------------------
    // Sequencer next values
    // ------------------------------------------------------------
    always_comb begin
        logic finish;
        finish          = 1'b0;
        next_state      = state;
        next_idx        = idx;
        next_pattern    = pattern;
        next_bin        = bin;
        next_pass       = pass;
        next_busy       = busy;
        next_done       = 1'b0;
        next_feeds      = feeds;
        next_begin_prev = begin_level;
        case (state)
            ST_IDLE: begin
                if (TEST_ENABLE && start) begin // RQ1
                    next_state = ST_WAIT;
                    next_busy  = 1'b1; // RQ20
                    if (AUTO_CLEAR) begin // RQ3
                        next_pattern = `CLT_PAT_CLEAR;
                        next_bin     = `CLT_BIN_NONE;
                        next_pass    = 1'b0;
                    end
                end
            end
            ST_WAIT: begin
                if (MEAS_VALID) begin
                    // Divide by zero would be undefined: saturate
                    next_feeds.math  = MATH_RESULT - ofs; // RQ11
                    next_feeds.volts = VOLTS - ofs; // RQ5
                    next_feeds.amps  = AMPS - ofs;
                    next_feeds.res   = (AMPS == `CLT_ZERO)
                                       ? $signed(`CLT_RES_DIV0)
                                       : (VOLTS / AMPS) - ofs; // RQ11
                    next_idx   = `CLT_IDX_FIRST; // RQ12
                    next_state = ST_JUDGE;
                end
            end
            ST_JUDGE: begin
                if (cur_cfg.enable) begin // RQ12
                    if (!MODE_SORT) begin // RQ2
                        if (!cur_v.pass) begin
                            finish    = 1'b1;
                            next_bin  = idx;
                            next_pass = 1'b0;
                            if (cur_v.comp_fail) begin
                                next_pattern = cur_cfg.fail_pat; // RQ15
                            end else if (cur_v.up_fail) begin
                                next_pattern = cur_cfg.up_pat; // RQ16
                            end else begin
                                next_pattern = cur_cfg.low_pat; // RQ17
                            end
                        end else if (UPDATE_IMMEDIATE) begin // RQ4
                            next_pattern = COMP_PASS_PATTERN;
                            next_pass    = 1'b1;
                        end
                    end else if (cur_v.pass) begin
                        // Sorting: first passing test names the bin
                        finish       = 1'b1;
                        next_bin     = idx;
                        next_pass    = 1'b1;
                        next_pattern = cur_cfg.pass_pat;
                    end
                end
                if (!finish && idx == `CLT_IDX_LAST) begin
                    finish   = 1'b1;
                    next_bin = `CLT_BIN_NONE;
                    if (!MODE_SORT) begin
                        next_pattern = COMP_PASS_PATTERN; // RQ6
                        next_pass    = 1'b1;
                    end else begin
                        next_pattern = COMP_FAIL_PATTERN; // RQ6
                        next_pass    = 1'b0;
                    end
                end
                if (finish) begin
                    next_state = ST_IDLE;
                    next_busy  = 1'b0;
                    next_done  = 1'b1; // RQ20
                end else begin
                    next_idx = idx + `CLT_IDX_FIRST;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy  = 1'b0;
            end
        endcase
        // Disable aborts quietly, no done pulse
        if (!TEST_ENABLE && state != ST_IDLE) begin // RQ1
            next_state = ST_IDLE;
            next_busy  = 1'b0;
            next_done  = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state      <= ST_IDLE;
            idx        <= `CLT_IDX_FIRST;
            pattern    <= `CLT_PAT_CLEAR;
            bin        <= `CLT_BIN_NONE;
            pass       <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
            begin_prev <= 1'b1;
            feeds      <= '0;
        end else begin
            state      <= next_state;
            idx        <= next_idx;
            pattern    <= next_pattern;
            bin        <= next_bin;
            pass       <= next_pass;
            busy       <= next_busy;
            done       <= next_done;
            begin_prev <= next_begin_prev;
            feeds      <= next_feeds;
        end
    end

    // ------------------------------------------------------------
    // Pin mapping; pins lag the internal state by one cycle
    // ------------------------------------------------------------
    always_comb begin
        next_pin_out = '0;
        next_pin_oe  = '0;
        for (int p = 1; p <= `CLT_NPIN; p++) begin
            if (TEST_ENABLE && PIN_IS_DIGITAL[p]) begin // RQ10
                if (PATTERN_PIN_LOW != `CLT_PIN_NONE
                    && 4'(p) >= PATTERN_PIN_LOW
                    && 4'(p) <= PATTERN_PIN_HIGH) begin
                    next_pin_out[p] =
                        pattern[4'(p) - PATTERN_PIN_LOW]; // RQ8
                    next_pin_oe[p]  = 1'b1; // RQ18
                end
                if (BUSY_PIN == 4'(p)) begin
                    next_pin_out[p] = ~busy; // RQ9
                    next_pin_oe[p]  = 1'b1;
                end
                if (DONE_PIN == 4'(p)) begin
                    next_pin_out[p] = ~done; // RQ9
                    next_pin_oe[p]  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    // Outputs
    assign HANDLER_IO_PIN_OUT = pin_out;
    assign HANDLER_IO_PIN_OE  = pin_oe;
    assign TEST_BUSY          = busy;
    assign TEST_DONE          = done;
    assign RESULT_BIN         = bin;
    assign RESULT_PASS        = pass;
    assign RESULT_PATTERN     = pattern;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_accept;
        state == ST_IDLE && TEST_ENABLE && start;
    endsequence

    sequence s_busy_end;
        (busy && TEST_ENABLE) ##1 !busy;
    endsequence

    property p_off_no_drive; // RQ1
        !TEST_ENABLE |=> HANDLER_IO_PIN_OE == '0;
    endproperty
    a_off_no_drive: assert property (p_off_no_drive)
        else $error("pins driven while disabled");

    property p_accept_busy; // RQ20
        s_accept |=> TEST_BUSY ##0 (state == ST_WAIT);
    endproperty
    a_accept_busy: assert property (p_accept_busy)
        else $error("start not followed by busy");

    property p_done_after_busy; // RQ20
        s_busy_end |-> TEST_DONE ##1 !TEST_DONE;
    endproperty
    a_done_after_busy: assert property (p_done_after_busy)
        else $error("done pulse missing or too long");

    property p_auto_clear; // RQ3
        s_accept ##0 AUTO_CLEAR |=> RESULT_PATTERN == `CLT_PAT_CLEAR
                                    && RESULT_BIN == `CLT_BIN_NONE;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("auto clear did not clear results");

    property p_end_hold; // RQ4
        (state == ST_JUDGE && !MODE_SORT && !UPDATE_IMMEDIATE
         && next_state == ST_JUDGE && TEST_ENABLE)
        |=> $stable(RESULT_PATTERN);
    endproperty
    a_end_hold: assert property (p_end_hold)
        else $error("pattern changed before last test");

    property p_lsb_pin; // RQ8
        (TEST_ENABLE && PATTERN_PIN_LOW != `CLT_PIN_NONE
         && PATTERN_PIN_LOW <= PATTERN_PIN_HIGH
         && PATTERN_PIN_LOW != BUSY_PIN && PATTERN_PIN_LOW != DONE_PIN
         && pin_ok(PATTERN_PIN_LOW, PIN_IS_DIGITAL))
        |=> HANDLER_IO_PIN_OUT[$past(PATTERN_PIN_LOW)]
            == $past(pattern[0]);
    endproperty
    a_lsb_pin: assert property (p_lsb_pin)
        else $error("pattern LSB not on lowest pin");

    property p_dig_only; // RQ10
        1'b1 |=> (HANDLER_IO_PIN_OE & ~$past(PIN_IS_DIGITAL)) == '0;
    endproperty
    a_dig_only: assert property (p_dig_only)
        else $error("non-digital pin driven");

    property p_upper_fail; // RQ16
        (state == ST_JUDGE && TEST_ENABLE && !MODE_SORT
         && cur_cfg.enable && cur_cfg.func == FUNC_LIMIT
         && cur_v.up_fail)
        |=> RESULT_PATTERN == $past(cur_cfg.up_pat) && TEST_DONE
            && RESULT_BIN == $past(idx);
    endproperty
    a_upper_fail: assert property (p_upper_fail)
        else $error("upper failure not reported");

    property p_sort_none; // RQ6
        (state == ST_JUDGE && TEST_ENABLE && MODE_SORT
         && idx == `CLT_IDX_LAST && !(cur_cfg.enable && cur_v.pass))
        |=> RESULT_PATTERN == $past(COMP_FAIL_PATTERN) && !RESULT_PASS;
    endproperty
    a_sort_none: assert property (p_sort_none)
        else $error("sorting fail pattern missing");

endmodule // clt_top

/* File: verif/clt_handler_model.sv */
// Handler on the far side of the pins: start request, pattern capture.
// Assumes a 4-pin pattern run starting at pat_lo; pulled-up lines.
module clt_handler_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [14:1] pin_out,
    input  wire logic [14:1] pin_oe,
    input  wire logic [3:0]  begin_pin,
    input  wire logic [3:0]  done_pin,
    input  wire logic [3:0]  pat_lo,
    output logic      [14:1] pin_in,
    output logic      [3:0]  cap
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Wire levels and capture
    // ----------------------------------------
    // Released lines float up; begin is pulled low while go is held
    always_comb begin
        for (int p = 1; p <= 14; p++) begin
            pin_in[p] = pin_oe[p] ? pin_out[p]
                                  : !(go && begin_pin == p);
        end
    end

    // Read the pattern only while done is low, never earlier
    always_ff @(posedge clk) begin
        if (pin_in[done_pin] == 1'b0) begin
            cap <= pin_in[pat_lo +: 4];
        end
    end
endmodule // clt_handler_model

/* File: verif/test_clt_top.sv */
// Self-checking bench for clt_top with a handler model on the pins.
// Assumes clt_pkg compiled first and clt_defines.svh on the path.
`include "clt_defines.svh"
module test_clt_top;
    timeunit 1ns;
    timeprecision 100ps;
    import clt_pkg::*;
    logic clk, rst_n, en, sort, aclr, imm, ocan, mv, inc, go;
    logic signed [71:0] ofs, math, volts, amps;
    logic [13:0]        cpass, cfail, rpat;
    logic [14:1]        dig, pin_in, pin_out, pin_oe;
    logic               busy, done, rpass, seen;
    logic [3:0]         bin, cap, plo, phi, bsp, bgp, dnp;
    clt_test_cfg_type   cfg [12];
    int                 mismatches, n_tests;

    clt_top u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .TEST_ENABLE(en),
        .MODE_SORT(sort), .AUTO_CLEAR(aclr), .UPDATE_IMMEDIATE(imm),
        .OFFSET_CANCEL(ocan), .OFFSET(ofs), .COMP_PASS_PATTERN(cpass),
        .COMP_FAIL_PATTERN(cfail), .PATTERN_PIN_LOW(plo),
        .PATTERN_PIN_HIGH(phi), .BUSY_PIN(bsp), .BEGIN_PIN(bgp),
        .DONE_PIN(dnp), .PIN_IS_DIGITAL(dig), .TEST_CFG(cfg),
        .MEAS_VALID(mv), .MATH_RESULT(math), .VOLTS(volts), .AMPS(amps),
        .IN_COMPLIANCE(inc), .HANDLER_IO_PIN_IN(pin_in),
        .HANDLER_IO_PIN_OUT(pin_out), .HANDLER_IO_PIN_OE(pin_oe),
        .TEST_BUSY(busy), .TEST_DONE(done), .RESULT_BIN(bin),
        .RESULT_PASS(rpass), .RESULT_PATTERN(rpat));

    clt_handler_model u_hdl (.clk(clk), .go(go), .pin_out(pin_out),
        .pin_oe(pin_oe), .begin_pin(bgp), .done_pin(dnp),
        .pat_lo(plo), .pin_in(pin_in), .cap(cap));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(string nm, logic [71:0] s, logic [71:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Limit test with distinct pattern nibbles per outcome
    function automatic clt_test_cfg_type lim(clt_feed_sel_type f,
                                             int up, int lo);
        return '{enable:1'b1, func:FUNC_LIMIT, feed:f, fail_on_in:1'b0,
                 fail_pat:14'h0009, pass_pat:14'h000C, up_pat:14'h0003,
                 low_pat:14'h0005, up_limit:72'(up), low_limit:72'(lo)};
    endfunction

    // One handler transfer; bounded waits so a hang still reports
    task automatic run(logic p, logic [3:0] b, logic [13:0] pat);
        int i;
        @(posedge clk);
        go <= 1'b1;
        i = 0;
        do begin @(negedge clk); i++; end while (busy !== 1'b1 && i < 20);
        chk("busy", busy, 1'b1);
        if (aclr) chk("clear", rpat, 14'h0000);
        @(posedge clk);
        go <= 1'b0;
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        i = 0;
        seen = 1'b0;
        // Note whether the composite pass pattern showed before or with done
        do begin
            @(negedge clk);
            i++;
            if (rpat === cpass) seen = 1'b1;
        end while (done !== 1'b1 && i < 40);
        chk("done", done, 1'b1);
        chk("busy_pin", pin_in[bsp], 1'b0);
        chk("busy_end", busy, 1'b0);
        chk("pass", rpass, p);
        chk("bin", bin, b);
        chk("pattern", rpat, pat);
        repeat (4) @(negedge clk);
        chk("pins", cap, pat[3:0]);
        @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_limit();
        @(posedge clk);
        cfg[0] <= lim(FEED_VOLTS, 100, -100);
        volts <= 72'sh65;
        run(1'b0, 4'h1, 14'h0003);
        aclr <= 1'b1;
        volts <= -72'sh65;
        run(1'b0, 4'h1, 14'h0005);
        aclr <= 1'b0;
        volts <= 72'sh64;
        run(1'b1, 4'h0, 14'h0006);
        $display("t_limit finished");
    endtask

    task automatic t_sort();
        @(posedge clk);
        sort <= 1'b1;
        cfg[0] <= lim(FEED_VOLTS, 10, -10);
        cfg[1] <= lim(FEED_VOLTS, 100, -100);
        volts <= 72'sh32;
        run(1'b1, 4'h2, 14'h000C);
        cfg[1].enable <= 1'b0;
        run(1'b0, 4'h0, 14'h000A);
        sort <= 1'b0;
        $display("t_sort finished");
    endtask

    task automatic t_comp();
        @(posedge clk);
        cfg[0].func <= FUNC_COMP;
        cfg[0].fail_on_in <= 1'b1;
        inc <= 1'b1;
        run(1'b0, 4'h1, 14'h0009);
        cfg[0].fail_on_in <= 1'b0;
        run(1'b1, 4'h0, 14'h0006);
        inc <= 1'b0;
        run(1'b0, 4'h1, 14'h0009);
        $display("t_comp finished");
    endtask

    task automatic t_feed();
        @(posedge clk);
        cfg[0] <= lim(FEED_RES, 99, 0);
        volts <= 72'sh3E8;
        amps <= 72'shA;
        run(1'b0, 4'h1, 14'h0003);
        volts <= -72'sh3E8;
        cfg[0] <= lim(FEED_RES, 99, -99);
        run(1'b0, 4'h1, 14'h0005);
        cfg[0] <= lim(FEED_VOLTS, 100, -100);
        ocan <= 1'b1;
        volts <= 72'sh78;
        run(1'b1, 4'h0, 14'h0006);
        ocan <= 1'b0;
        cfg[0] <= lim(FEED_AMPS, 20, 15);
        run(1'b0, 4'h1, 14'h0005);
        cfg[0] <= lim(FEED_MATH, 6, 0);
        run(1'b0, 4'h1, 14'h0003);
        $display("t_feed finished");
    endtask

    // Grading with a passing first test and a failing last one
    task automatic t_imm();
        @(posedge clk);
        {aclr, imm} <= 2'b11;
        cfg[0] <= lim(FEED_VOLTS, 100, -100);
        cfg[11] <= lim(FEED_VOLTS, 10, -10);
        volts <= 72'sh32;
        run(1'b0, 4'hC, 14'h0003);
        chk("imm_mid", seen, 1'b1);
        imm <= 1'b0;
        run(1'b0, 4'hC, 14'h0003);
        chk("end_mid", seen, 1'b0);
        aclr <= 1'b0;
        cfg[11].enable <= 1'b0;
        $display("t_imm finished");
    endtask

    task automatic t_gate();
        @(posedge clk);
        en <= 1'b0;
        go <= 1'b1;
        repeat (6) @(negedge clk);
        chk("off_busy", busy, 1'b0);
        chk("off_oe", pin_oe, 14'h0000);
        @(posedge clk);
        go <= 1'b0;
        dig[3] <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        repeat (3) @(negedge clk);
        chk("nondig_oe", pin_oe[3], 1'b0);
        @(posedge clk);
        dig[3] <= 1'b1;
        bgp <= 4'h0;
        go <= 1'b1;
        repeat (4) @(negedge clk);
        chk("unassigned", busy, 1'b0);
        @(posedge clk);
        bgp <= 4'h7;
        go <= 1'b0;
        $display("t_gate finished");
    endtask

    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        {rst_n, sort, aclr, imm, ocan, mv, inc, go} = '0;
        en = 1'b1;
        {ofs, amps} = {72'sh32, 72'sh1};
        {math, volts} = {72'sh7, 72'sh0};
        {cpass, cfail} = {14'h0006, 14'h000A};
        dig = 14'h3FFF;
        {plo, phi, bsp, bgp, dnp} = {4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
        foreach (cfg[i]) cfg[i] = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_limit();
        t_sort();
        t_comp();
        t_feed();
        t_imm();
        t_gate();
        results();
    end

    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule // test_clt_top
